/* File: verilog/flash_ctl_consts.vh */
`ifndef FLASH_CTL_CONSTS_VH
`define FLASH_CTL_CONSTS_VH
// Register byte offsets of the controller's own registers
`define OFS_CTRL      12'h000
`define OFS_ADDR      12'h004
`define OFS_WDATA     12'h008
`define OFS_STATUS    12'h00c
`define OFS_RDATA     12'h010
`define OFS_PULSE     12'h014
// Control register fields
`define CTRL_GO_BIT   0
`define CTRL_OP_LSB   1
`define CTRL_OP_MSB   3
`define CTRL_TMPU_BIT 4
// Operation codes
`define OP_READ       3'h0
`define OP_WRITE      3'h1
`define OP_PROTECT    3'h2
`define OP_UNPROTECT  3'h3
`define OP_VERIFY     3'h4
`define OP_ERASE_ADD  3'h5
// Status register fields
`define ST_BUSY_BIT   0
`define ST_REJ_BIT    1
`define ST_PROT_BIT   2
// Reset values
`define CTRL_RESET    32'h0000_0000
`define PULSE_RESET   32'h0000_0019
// Timing: noise pulses shorter than this are filtered by the device
`define GLITCH_NS     5
// Clock period in ns
`define CLK_NS        4
// Least strobe width in ns (write pulse plus margin)
`define WP_NS         40
// Least setup of high voltage to strobe, in ns
`define HV_SETUP_NS   4000
// Least protect strobe width in ns
`define WPP_NS        100
// Verify read settle time in ns
`define RD_NS         100
// Sector erase command data, reset and identifier read codes
`define CMD_RESET     8'hf0
`define CMD_IDREAD    8'h90
`define CMD_SECT_ERA  8'h30
`endif

/* File: verilog/pulse_timer.v */
`timescale 1ns/10ps
`default_nettype none
// Loadable down counter used for every timed phase of the pin sequence
module pulse_timer #(
  parameter W = 16
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         load,
  input  wire [W-1:0] count,
  output reg          done
);
  reg [W-1:0] remain;

  // Done is a level, high once the loaded count has run out
  always @(posedge aclk) begin
    if (!aresetn) begin
      remain <= {W{1'b0}};
      done   <= 1'b1;
    end else if (load) begin
      remain <= count;
      done   <= 1'b0;
    end else if (remain != {W{1'b0}}) begin
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
      done   <= (remain == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule
`default_nettype wire

/* File: verilog/flash_host_ctl.v */
// Summary of operation
// - Host checks window flag after each add
// - Write needs select, strobe low, gate high
// - High voltage on reset: temporary unprotect
// - Protect pulse on strobe with high voltage
// - Host writes reset to leave identifier read
// - Unprotect: high voltage, address bit six high
// - Protect all sectors before chip unprotect (OP_UNPROTECT does not do this first)
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_consts.vh"
module flash_host_ctl #(
  parameter AW = 20,
  parameter TW = 16
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [11:0]   s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [11:0]   s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  output reg  [AW-1:0] flash_addr,
  output reg  [7:0]    flash_dq_out,
  output reg           flash_dq_oe,
  input  wire [7:0]    flash_dq_in,
  output reg           flash_ce_n,
  output reg           flash_oe_n,
  output reg           flash_we_n,
  output reg           addr_nine_hv,
  output reg           gate_hv,
  output reg           reset_hv
);
  localparam [TW-1:0] WP_CYC  = (`WP_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [TW-1:0] HV_CYC  = (`HV_SETUP_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [TW-1:0] RD_CYC  = (`RD_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [TW-1:0] WPP_CYC = (`WPP_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_SETUP = 6'h02;
  localparam [5:0] S_LOW   = 6'h04;
  localparam [5:0] S_HIGH  = 6'h08;
  localparam [5:0] S_READ  = 6'h10;
  localparam [5:0] S_DONE  = 6'h20;
  reg [5:0]    state;
  reg [2:0]    op, go_op;
  reg [AW-1:0] addr_reg;
  reg [7:0]    wdata_reg, rdata_reg;
  reg [31:0]   pulse_reg, w_data;
  reg          busy, rejected, prot_seen, tmp_unprot;
  reg          tload, aw_held, w_held, go;
  reg [TW-1:0] tcount;
  reg [11:0]   aw_addr;
  wire         tdone;
  function is_hv_op;
    input [2:0] o;
    begin
      is_hv_op = (o == `OP_PROTECT) || (o == `OP_UNPROTECT) || (o == `OP_VERIFY);
    end
  endfunction
  pulse_timer #(.W(TW)) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (tload),
    .count   (tcount),
    .done    (tdone)
  );
  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      go            <= 1'b0;
      go_op         <= `OP_READ;
      addr_reg      <= {AW{1'b0}};
      wdata_reg     <= 8'h00;
      pulse_reg     <= `PULSE_RESET;
      tmp_unprot    <= 1'b0;
    end else begin
      go <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (aw_addr)
          `OFS_CTRL: begin
            // A start while busy is dropped rather than queued
            if (w_data[`CTRL_GO_BIT] && !busy) begin
              go    <= 1'b1;
              go_op <= w_data[`CTRL_OP_MSB:`CTRL_OP_LSB];
            end
            tmp_unprot <= w_data[`CTRL_TMPU_BIT];
          end
          `OFS_ADDR:  addr_reg  <= w_data[AW-1:0];
          `OFS_WDATA: wdata_reg <= w_data[7:0];
          `OFS_PULSE: pulse_reg <= w_data;
          default:    s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side, one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      case (s_axi_araddr)
        `OFS_CTRL:   s_axi_rdata <= {27'h0, tmp_unprot, op, 1'b0};
        `OFS_ADDR:   s_axi_rdata <= {{(32-AW){1'b0}}, addr_reg};
        `OFS_WDATA:  s_axi_rdata <= {24'h0, wdata_reg};
        `OFS_STATUS: s_axi_rdata <= {29'h0, prot_seen, rejected, busy};
        `OFS_RDATA:  s_axi_rdata <= {24'h0, rdata_reg};
        `OFS_PULSE:  s_axi_rdata <= pulse_reg;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Pin sequencer; pins idle deselected so nothing is mistaken for a write
  always @(posedge aclk) begin
    if (!aresetn) begin
      state         <= S_IDLE;
      op            <= `OP_READ;
      busy          <= 1'b0;
      rejected      <= 1'b0;
      prot_seen     <= 1'b0;
      rdata_reg     <= 8'h00;
      flash_addr    <= {AW{1'b0}};
      flash_dq_out  <= 8'h00;
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      addr_nine_hv  <= 1'b0;
      gate_hv       <= 1'b0;
      reset_hv      <= 1'b0;
      tload         <= 1'b0;
      tcount        <= {TW{1'b0}};
    end else begin
      tload    <= 1'b0;
      reset_hv <= tmp_unprot;
      case (state)
        S_IDLE: begin
          if (go) begin
            op         <= go_op;
            busy       <= 1'b1;
            flash_addr <= addr_reg;
            if (go_op == `OP_UNPROTECT)
              flash_addr[6] <= 1'b1;
            if (go_op == `OP_VERIFY)
              flash_addr[6:0] <= {1'b0, addr_reg[5:2], 2'b10};
            if (go_op == `OP_ERASE_ADD)
              rejected <= 1'b0;
            addr_nine_hv <= is_hv_op(go_op);
            gate_hv      <= (go_op == `OP_PROTECT) || (go_op == `OP_UNPROTECT);
            tload        <= 1'b1;
            tcount       <= is_hv_op(go_op) ? HV_CYC : {{(TW-1){1'b0}}, 1'b1};
            state        <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (tdone && !tload) begin
            tload <= 1'b1;
            case (op)
              `OP_READ, `OP_VERIFY: begin
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                tcount     <= RD_CYC;
                state      <= S_READ;
              end
              `OP_WRITE, `OP_ERASE_ADD: begin
                flash_dq_out <= (op == `OP_ERASE_ADD) ? `CMD_SECT_ERA : wdata_reg;
                flash_dq_oe  <= 1'b1;
                flash_ce_n   <= 1'b0;
                flash_oe_n   <= 1'b1;
                flash_we_n   <= 1'b0;
                tcount       <= WP_CYC;
                state        <= S_LOW;
              end
              default: begin
                // Long strobe, software may stretch it beyond the least width
                flash_ce_n <= 1'b0;
                flash_we_n <= 1'b0;
                tcount     <= (pulse_reg[TW-1:0] > WPP_CYC) ? pulse_reg[TW-1:0] : WPP_CYC;
                state      <= S_LOW;
              end
            endcase
          end
        end
        S_LOW: begin
          if (tdone && !tload) begin
            flash_we_n <= 1'b1;
            tload      <= 1'b1;
            tcount     <= WP_CYC;
            state      <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (tdone && !tload) begin
            flash_ce_n  <= 1'b1;
            flash_dq_oe <= 1'b0;
            if (op == `OP_ERASE_ADD) begin
              // Read window flag after the add to see if it was taken
              flash_ce_n <= 1'b0;
              flash_oe_n <= 1'b0;
              tload      <= 1'b1;
              tcount     <= RD_CYC;
              state      <= S_READ;
            end else
              state <= S_DONE;
          end
        end
        S_READ: begin
          if (tdone && !tload) begin
            rdata_reg  <= flash_dq_in;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (op == `OP_VERIFY || op == `OP_READ)
              prot_seen <= flash_dq_in[0];
            if (op == `OP_ERASE_ADD)
              rejected <= flash_dq_in[3];
            state <= S_DONE;
          end
        end
        S_DONE: begin
          addr_nine_hv <= 1'b0;
          gate_hv      <= 1'b0;
          busy         <= 1'b0;
          state        <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: dv/flash_host_ctl_props.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctl_props #(
  parameter AW = 20
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic [AW-1:0] flash_addr,
  input wire logic          flash_dq_oe,
  input wire logic          flash_ce_n,
  input wire logic          flash_oe_n,
  input wire logic          flash_we_n,
  input wire logic          addr_nine_hv,
  input wire logic          gate_hv
);
  logic [15:0] hv_cnt;
  logic [15:0] low_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Run lengths of high voltage and strobe low; 16 bits outlast any legal phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hv_cnt  <= 16'h0000;
      low_cnt <= 16'h0000;
    end else begin
      hv_cnt  <= addr_nine_hv ? hv_cnt + 16'h0001 : 16'h0000;
      low_cnt <= flash_we_n ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  // Pin sequencing
  a_reset_idle: assert property ($rose(aresetn) |-> flash_we_n && flash_ce_n && !flash_dq_oe && !addr_nine_hv)
    else $error("pins not idle after reset");
  a_write_qual: assert property (!flash_we_n && !gate_hv |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without select or with gate low");
  a_strobe_width: assert property ($fell(flash_we_n) |=> !flash_we_n)
    else $error("write strobe too short");
  a_dq_contend: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("data driven while gate low");
  a_hv_setup: assert property ($fell(flash_we_n) && addr_nine_hv |-> hv_cnt >= 16'h03e7)
    else $error("high voltage setup too short");
  a_hv_pulse: assert property ($rose(flash_we_n) && addr_nine_hv |-> low_cnt >= 16'h0019)
    else $error("protect strobe too short");
  a_hv_gate: assert property (!flash_we_n && addr_nine_hv |-> gate_hv)
    else $error("protect strobe without gate high voltage");
  a_unprot_select: assert property (!flash_we_n && addr_nine_hv && flash_addr[6] |-> !flash_ce_n)
    else $error("unprotect without chip select");
  a_hv_release: assert property ($fell(addr_nine_hv) |-> flash_we_n && $past(flash_we_n))
    else $error("high voltage removed inside strobe");
  a_verify_addr: assert property (!flash_oe_n && addr_nine_hv && !gate_hv |-> flash_addr[1] && !flash_addr[0])
    else $error("verify read with wrong address bits");
  c_protect: cover property ($rose(flash_we_n) && addr_nine_hv && !flash_addr[6]);
  c_unprotect: cover property ($rose(flash_we_n) && addr_nine_hv && flash_addr[6]);
  c_verify: cover property (!flash_oe_n && addr_nine_hv);
endmodule
bind flash_host_ctl flash_host_ctl_props #(.AW(AW)) u_props (.aclk, .aresetn, .flash_addr, .flash_dq_oe,
  .flash_ce_n, .flash_oe_n, .flash_we_n, .addr_nine_hv, .gate_hv);
`default_nettype wire

/* File: dv/flash_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
  parameter AW     = 20,
  parameter WIN_NS = 20000,
  parameter ERA_NS = 20000,
  parameter ID_VAL = 8'h5c
) (
  input  wire logic [AW-1:0] flash_addr,
  input  wire logic [7:0]    flash_dq_out,
  output wire logic [7:0]    flash_dq_in,
  input  wire logic          flash_ce_n,
  input  wire logic          flash_oe_n,
  input  wire logic          flash_we_n,
  input  wire logic          addr_nine_hv,
  input  wire logic          gate_hv,
  input  wire logic          reset_hv
);
  logic [15:0] prot;
  logic [7:0]  val;
  logic [7:0]  hold;
  logic        id_mode;
  logic        erasing;
  logic        win_flag;
  realtime     t_fall;
  wire  [3:0]  sec = flash_addr[15:12];
  wire         rd_en = !flash_ce_n && !flash_oe_n;
  // Power-up in array read; ID_VAL is arbitrary
  initial begin
    prot = 16'h0000;
    id_mode = 1'b0;
    erasing = 1'b0;
    win_flag = 1'b0;
    hold = 8'h00;
    t_fall = 1.0e9;
  end
  always @(negedge flash_we_n) t_fall = $realtime;
  ////////////////////////////////////////
  // Writes land on the strobe rise; a far t_fall blocks the power-up edge
  always @(posedge flash_we_n) begin
    if ($realtime - t_fall >= 5.0) begin
      if (addr_nine_hv && gate_hv && flash_addr[6] && !flash_ce_n)
        prot = 16'h0000;
      else if (addr_nine_hv && gate_hv)
        prot[sec] = 1'b1;
      else if (!flash_ce_n && flash_oe_n && !win_flag) begin
        if (flash_dq_out == 8'h90)
          id_mode = 1'b1;
        else if (flash_dq_out == 8'hf0)
          id_mode = 1'b0;
        else if (flash_dq_out == 8'h30 && (!prot[sec] || reset_hv))
          erasing = 1'b1;
      end
    end
  end
  // Add window, then the erase itself
  always @(posedge erasing) begin
    win_flag = 1'b0;
    #(WIN_NS);
    win_flag = 1'b1;
    #(ERA_NS);
    erasing = 1'b0;
    win_flag = 1'b0;
  end
  // Read data by mode
  always @* begin
    if ((addr_nine_hv || id_mode) && flash_addr[1])
      val = {7'h00, prot[sec]};
    else if (addr_nine_hv || id_mode)
      val = ID_VAL;
    else if (erasing)
      val = {4'h0, win_flag, 3'h0};
    else
      val = 8'hff;
  end
  // A released bus shows the inverse, so a stale byte is never mistaken for data
  always @(val or rd_en) if (rd_en) hold = val;
  assign flash_dq_in = rd_en ? val : ~hold;
endmodule
`default_nettype wire

/* File: dv/flash_host_ctl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_consts.vh"
module flash_host_ctl_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd_data, st;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rd_resp, wr_resp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [19:0] flash_addr;
  wire  [7:0]  flash_dq_out, flash_dq_in;
  wire         flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, addr_nine_hv, gate_hv, reset_hv;
  int          n_errors, checked;
  flash_host_ctl #(.AW(20)) u_dut (.*);
  flash_dev_model u_dev (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // Responses are always accepted, so bready stays high
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit pa, pw;
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    wr_resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  // Run one operation, wait out busy, keep status and read byte
  task automatic op(input logic [2:0] code, input logic [19:0] a, input logic [7:0] d, input logic tm);
    int n;
    wr(`OFS_ADDR, {12'h000, a});
    wr(`OFS_WDATA, {24'h000000, d});
    wr(`OFS_CTRL, {27'h0000000, tm, code, 1'b1});
    n = 0;
    do begin
      rd(`OFS_STATUS);
      n++;
    end while (rd_data[`ST_BUSY_BIT] !== 1'b0 && n < 3000);
    // A poll limit that runs out is a hang, so end the run here
    if (rd_data[`ST_BUSY_BIT] !== 1'b0) begin
      n_errors++;
      stop_test;
    end
    st = rd_data;
    rd(`OFS_RDATA);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk({flash_we_n, flash_ce_n, flash_oe_n, flash_dq_oe, addr_nine_hv}, 5'h1c);
    rd(`OFS_CTRL);
    chk(rd_data, `CTRL_RESET);
    rd(`OFS_PULSE);
    chk(rd_data, `PULSE_RESET);
    rd(12'h020);
    chk(rd_resp, 2'h2);
    wr(`OFS_STATUS, 32'h00000000);
    chk(wr_resp, 2'h2);
    $display("reset test done");
  endtask
  task automatic t_tmpu;
    wr(`OFS_CTRL, 32'h00000010);
    repeat (2) @(posedge aclk);
    chk(reset_hv, 1'b1);
    wr(`OFS_CTRL, 32'h00000000);
    repeat (2) @(posedge aclk);
    chk(reset_hv, 1'b0);
    $display("temporary unprotect test done");
  endtask
  task automatic t_protect;
    op(`OP_PROTECT, 20'h03000, 8'h00, 1'b0);
    op(`OP_VERIFY, 20'h03000, 8'h00, 1'b0);
    chk(st[`ST_PROT_BIT], 1'b1);
    chk(rd_data, 32'h00000001);
    op(`OP_VERIFY, 20'h05000, 8'h00, 1'b0);
    chk(rd_data, 32'h00000000);
    $display("protect test done");
  endtask
  task automatic t_idread;
    op(`OP_WRITE, 20'h00000, `CMD_IDREAD, 1'b0);
    op(`OP_READ, 20'h03002, 8'h00, 1'b0);
    chk(rd_data, 32'h00000001);
    op(`OP_READ, 20'h05002, 8'h00, 1'b0);
    chk(rd_data, 32'h00000000);
    op(`OP_WRITE, 20'h00000, `CMD_RESET, 1'b0);
    op(`OP_READ, 20'h03002, 8'h00, 1'b0);
    chk(rd_data, 32'h000000ff);
    $display("identifier test done");
  endtask
  // Wait covers the model's add window of 5000 cycles
  task automatic t_erase;
    op(`OP_ERASE_ADD, 20'h03000, 8'h00, 1'b0);
    chk(st[`ST_REJ_BIT], 1'b1);
    op(`OP_ERASE_ADD, 20'h03000, 8'h00, 1'b1);
    chk(st[`ST_REJ_BIT], 1'b0);
    op(`OP_ERASE_ADD, 20'h01000, 8'h00, 1'b0);
    chk(st[`ST_REJ_BIT], 1'b0);
    repeat (5000) @(posedge aclk);
    op(`OP_ERASE_ADD, 20'h02000, 8'h00, 1'b0);
    chk(st[`ST_REJ_BIT], 1'b1);
    $display("erase window test done");
  endtask
  task automatic t_unprot;
    op(`OP_UNPROTECT, 20'h00000, 8'h00, 1'b0);
    op(`OP_VERIFY, 20'h03000, 8'h00, 1'b0);
    chk(rd_data, 32'h00000000);
    $display("unprotect test done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Tests need about 11000 cycles; 50000 means a hang
  initial begin
    #200000;
    n_errors++;
    stop_test;
  end
  initial begin
    n_errors = 0;
    checked = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_tmpu;
    t_protect;
    t_idread;
    t_erase;
    t_unprot;
    stop_test;
  end
endmodule
`default_nettype wire
